// File: swmon_host_model.sv
/*
 * Host serial master model: one 32-bit frame per call, 12 ns serial clock.
 * Assumes frame() is called from one process at a time.
 */
`timescale 1ns/1ps
module swmon_host_model (
    output logic      o_spi_sclk,
    output logic      o_spi_cs_n,
    output logic      o_spi_mosi,
    input  wire logic i_spi_miso
);
    initial begin
        o_spi_sclk = 1'b0;
        o_spi_cs_n = 1'b1;
        o_spi_mosi = 1'b0;
    end

    task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
        o_spi_cs_n = 1'b0;
        #20;
        for (int i = 31; i >= 0; i--) begin
            o_spi_mosi = tx[i];
            #6 o_spi_sclk = 1'b1;
            #6 o_spi_sclk = 1'b0;
            rx[i] = i_spi_miso;
        end
        // Released data line must not look valid
        o_spi_mosi = ~o_spi_mosi;
        #300 o_spi_cs_n = 1'b1;
        #400;
    endtask : frame
endmodule : swmon_host_model

// File: swmon_irq_lowpower.sv
/*
 * Interrupt enable and low-power timing registers of the switch monitor, with the change-of-state
 * interrupt, the periodic wake timer and the polling pulse generator.
 * Assumes switch levels arrive asynchronously on pins, the host reaches the registers through
 * 32-bit serial frames on its own clock, and the low-power request comes from logic on i_clk.
 */
`timescale 1ns/1ps
module swmon_irq_lowpower
    import swmon_pkg::*;
#(
    parameter int TICK_CYCLES        = MS_TICK_CYCLES,
    parameter int GND_ON_CYCLES      = GND_POLL_ON_CYCLES,
    parameter int BAT_ON_CYCLES      = BAT_POLL_ON_CYCLES
) (
    input  wire logic                i_clk,
    input  wire logic                i_sys_rst,
    input  wire logic                i_spi_sclk,
    input  wire logic                i_spi_cs_n,
    input  wire logic                i_spi_mosi,
    input  wire logic [NUM_PROG-1:0] i_programmable_input,
    input  wire logic [NUM_GND-1:0]  i_ground_switch_input,
    input  wire logic                i_low_power_req,
    output logic                     o_spi_miso,
    output logic                     o_spi_miso_oe,
    output logic                     o_irq_n,
    output logic                     o_irq_pending_flag,
    output logic                     o_low_power_state,
    output logic                     o_ground_poll_en,
    output logic                     o_battery_poll_en
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    localparam int TICK_W = $clog2(TICK_CYCLES);
    localparam int ON_W   = $clog2((GND_ON_CYCLES > BAT_ON_CYCLES ? GND_ON_CYCLES : BAT_ON_CYCLES) + 1);

    if (TICK_CYCLES < 2) begin : g_bad_tick
        $error("TICK_CYCLES must be at least 2");
    end
    if (GND_ON_CYCLES < 1 || BAT_ON_CYCLES < 1) begin : g_bad_on
        $error("Polling on times must be at least one cycle");
    end

    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
    localparam logic [ON_W-1:0]   GND_ON    = ON_W'(GND_ON_CYCLES);
    localparam logic [ON_W-1:0]   BAT_ON    = ON_W'(BAT_ON_CYCLES);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        mode_t                 mode;
        logic [NUM_PROG-1:0]   prog_en;
        logic [NUM_GND-1:0]    gnd_en;
        logic [7:0]            lp_cfg;
        logic                  irq;
        logic [NUM_PROG-1:0]   prog_s1;
        logic [NUM_PROG-1:0]   prog_s2;
        logic [NUM_PROG-1:0]   prog_prev;
        logic [NUM_GND-1:0]    gnd_s1;
        logic [NUM_GND-1:0]    gnd_s2;
        logic [NUM_GND-1:0]    gnd_prev;
        logic                  done_s1;
        logic                  done_s2;
        logic                  done_prev;
        logic                  cs_s1;
        logic                  cs_s2;
        logic [FRAME_BITS-1:0] resp;
        logic                  req_prev;
        logic [TICK_W-1:0]     tick_cnt;
        logic [MS_W-1:0]       int_ms;
        logic [MS_W-1:0]       poll_ms;
        logic [ON_W-1:0]       gnd_on;
        logic [ON_W-1:0]       bat_on;
        logic                  irq_n;
        logic                  miso_oe;
        logic                  gnd_poll;
        logic                  bat_poll;
    } core_t;

    core_t q;
    core_t next_q;

    logic [FRAME_BITS-1:0] rx_word;
    logic                  rx_done;
    logic                  link_miso;

    // ------------------------------------------------------------------
    // Serial link (host clock domain)
    // ------------------------------------------------------------------
    swmon_serial_link u_link (
        .i_spi_sclk (i_spi_sclk),
        .i_spi_cs_n (i_spi_cs_n),
        .i_spi_mosi (i_spi_mosi),
        .i_tx_word  (q.resp),
        .o_rx_word  (rx_word),
        .o_rx_done  (rx_done),
        .o_miso     (link_miso)
    );

    // Readback of a register, unimplemented bits and unmapped addresses as zero
    function automatic logic [RDATA_W-1:0] reg_read(input core_t s, input logic [6:0] addr);
        logic [RDATA_W-1:0] v;
        v = 22'h000000;
        unique case (addr)
            ADDR_PROG_IRQ_EN: v = RDATA_W'(s.prog_en);
            ADDR_GND_IRQ_EN:  v = RDATA_W'(s.gnd_en);
            ADDR_LP_CFG:      v = RDATA_W'(s.lp_cfg);
            default:          v = 22'h000000;
        endcase
        return v;
    endfunction : reg_read

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic                  frame_done;
    logic [6:0]            f_addr;
    logic                  f_write;
    logic [DATA_W-1:0]     f_data;
    logic                  cos_irq;
    logic                  wake_irq;
    logic                  tick;
    logic                  poll_evt;
    logic [MS_W-1:0]       int_len;
    logic [MS_W-1:0]       poll_len;

    always_comb begin
        next_q   = q;
        f_addr   = rx_word[ADDR_MSB:ADDR_LSB];
        f_write  = rx_word[RW_BIT];
        f_data   = rx_word[DATA_W-1:0];
        cos_irq  = 1'b0;
        wake_irq = 1'b0;
        poll_evt = 1'b0;
        int_len  = int_period_ms(q.lp_cfg[INT_SEL_MSB:INT_SEL_LSB]);
        poll_len = poll_period_ms(q.lp_cfg[POLL_SEL_MSB:POLL_SEL_LSB]);
        tick     = (q.tick_cnt == TICK_LAST);

        // Two-stage synchronisers; only the second stage is used downstream
        next_q.prog_s1   = i_programmable_input;
        next_q.prog_s2   = q.prog_s1;
        next_q.prog_prev = q.prog_s2;
        next_q.gnd_s1    = i_ground_switch_input;
        next_q.gnd_s2    = q.gnd_s1;
        next_q.gnd_prev  = q.gnd_s2;
        next_q.done_s1   = rx_done;
        next_q.done_s2   = q.done_s1;
        next_q.done_prev = q.done_s2;
        next_q.cs_s1     = i_spi_cs_n;
        next_q.cs_s2     = q.cs_s1;
        next_q.miso_oe   = ~q.cs_s2;
        next_q.req_prev  = i_low_power_req;
        frame_done       = q.done_s2 & ~q.done_prev;

        if (frame_done && f_write) begin
            unique case (f_addr)
                // bits above the implemented inputs are dropped
                ADDR_PROG_IRQ_EN: next_q.prog_en = f_data[NUM_PROG-1:0];
                ADDR_GND_IRQ_EN:  next_q.gnd_en  = f_data[NUM_GND-1:0];
                ADDR_LP_CFG:      next_q.lp_cfg  = f_data[7:0];
                default:          next_q.lp_cfg  = q.lp_cfg;
            endcase
        end

        // change of state counts only in normal mode
        if (q.mode == MODE_NORMAL) begin
            // gate each change by its enable bit
            cos_irq = |((q.prog_s2 ^ q.prog_prev) & q.prog_en) | |((q.gnd_s2 ^ q.gnd_prev) & q.gnd_en);
        end

        // Millisecond prescaler, restarted on entry so periods start cleanly
        next_q.tick_cnt = tick ? '0 : q.tick_cnt + TICK_W'(1);

        unique case (q.mode)
            MODE_NORMAL: begin
                next_q.gnd_on  = '0;
                next_q.bat_on  = '0;
                if (i_low_power_req && !q.req_prev) begin
                    next_q.mode     = MODE_LOW_POWER;
                    next_q.tick_cnt = '0;
                    next_q.int_ms   = '0;
                    next_q.poll_ms  = '0;
                end
            end
            MODE_LOW_POWER: begin
                if (tick) begin
                    if (q.poll_ms == poll_len - MS_W'(1)) begin
                        // polling event at the selected interval
                        poll_evt       = 1'b1;
                        next_q.poll_ms = '0;
                    end else begin
                        next_q.poll_ms = q.poll_ms + MS_W'(1);
                    end
                    if (int_len != '0) begin
                        if (q.int_ms == int_len - MS_W'(1)) begin
                            wake_irq      = 1'b1;
                            next_q.int_ms = '0;
                        end else begin
                            next_q.int_ms = q.int_ms + MS_W'(1);
                        end
                    end
                end
                // current sources on for each group's on time
                if (poll_evt) begin
                    next_q.gnd_on = GND_ON;
                    next_q.bat_on = BAT_ON;
                end else begin
                    next_q.gnd_on = (q.gnd_on != '0) ? q.gnd_on - ON_W'(1) : '0;
                    next_q.bat_on = (q.bat_on != '0) ? q.bat_on - ON_W'(1) : '0;
                end
                if (wake_irq || !i_low_power_req) begin
                    next_q.mode   = MODE_NORMAL;
                    next_q.gnd_on = '0;
                    next_q.bat_on = '0;
                end
            end
        endcase
        next_q.gnd_poll = (next_q.gnd_on != '0);
        next_q.bat_poll = (next_q.bat_on != '0);

        // Completed frame clears the flag, but a new event in the same cycle wins
        next_q.irq   = (q.irq & ~frame_done) | cos_irq | wake_irq;
        next_q.irq_n = ~next_q.irq;

        // Response for the next frame reports the flag as it stood before the clear
        if (frame_done) begin
            next_q.resp = {f_addr, f_write, 1'b0, q.irq, reg_read(next_q, f_addr)};
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            q          <= '0;
            q.mode     <= MODE_NORMAL;
            q.prog_en  <= PROG_IRQ_EN_RST;
            q.gnd_en   <= GND_IRQ_EN_RST;
            q.lp_cfg   <= LP_CFG_RST;
            q.irq_n    <= 1'b1;
            q.cs_s1    <= 1'b1;
            q.cs_s2    <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    assign o_spi_miso         = link_miso;
    assign o_spi_miso_oe      = q.miso_oe;
    assign o_irq_n            = q.irq_n;
    assign o_irq_pending_flag = q.irq;
    assign o_low_power_state  = (q.mode == MODE_LOW_POWER);
    assign o_ground_poll_en   = q.gnd_poll;
    assign o_battery_poll_en  = q.bat_poll;

endmodule : swmon_irq_lowpower

// File: swmon_irq_lowpower_monitor.sv
/*
 * Checker for the interrupt and low-power block: pin mirror, poll pulses, wake interrupt.
 * Assumes it is bound into swmon_irq_lowpower and sees only its ports.
 */
`timescale 1ns/1ps
module swmon_irq_lowpower_monitor #(
    parameter int GND_ON_CYCLES = 3,
    parameter int BAT_ON_CYCLES = 5
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_spi_cs_n,
    input wire logic i_low_power_req,
    input wire logic o_irq_n,
    input wire logic o_irq_pending_flag,
    input wire logic o_low_power_state,
    input wire logic o_ground_poll_en,
    input wire logic o_battery_poll_en
);
    // ------------------------------------------------------------
    // Pulse length counters
    // ------------------------------------------------------------
    int gnd_len;
    int bat_len;

    always_ff @(posedge i_clk) begin
        gnd_len <= (i_sys_rst || !o_ground_poll_en) ? 0 : gnd_len + 1;
        bat_len <= (i_sys_rst || !o_battery_poll_en) ? 0 : bat_len + 1;
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_IRQ_PIN_MIRROR: assert property (o_irq_n == !o_irq_pending_flag)
        else $error("irq pin differs from pending flag");
    AST_GND_POLL_LEN: assert property ($fell(o_ground_poll_en) |-> gnd_len == GND_ON_CYCLES)
        else $error("ground poll pulse length wrong");
    AST_BAT_POLL_LEN: assert property ($fell(o_battery_poll_en) |-> bat_len == BAT_ON_CYCLES)
        else $error("battery poll pulse length wrong");
    AST_POLL_GROUPS_TOGETHER: assert property ($rose(o_ground_poll_en) |-> $rose(o_battery_poll_en))
        else $error("poll groups did not start together");
    AST_NO_SWITCH_IRQ_IN_LP: assert property ($rose(o_irq_pending_flag) |-> !$past(o_low_power_state) || !o_low_power_state)
        else $error("flag rose while staying in low power");
    AST_WAKE_RAISES_IRQ: assert property ($fell(o_low_power_state) && i_low_power_req && $past(i_low_power_req)
        |-> o_irq_pending_flag)
        else $error("timer wake without interrupt");
    AST_LP_ENTRY: assert property ($rose(i_low_power_req) |=> o_low_power_state)
        else $error("low power not entered");
    AST_LP_EXIT: assert property (!i_low_power_req |=> !o_low_power_state)
        else $error("low power kept without request");
    AST_FLAG_STICKY: assert property (i_spi_cs_n [*8] |-> !$fell(o_irq_pending_flag))
        else $error("flag cleared without a frame");

    COV_WAKE: cover property ($fell(o_low_power_state) && i_low_power_req);
    COV_POLL: cover property ($rose(o_ground_poll_en));
    COV_FLAG: cover property ($rose(o_irq_pending_flag) && !o_low_power_state);
endmodule : swmon_irq_lowpower_monitor

bind swmon_irq_lowpower swmon_irq_lowpower_monitor #(
    .GND_ON_CYCLES(GND_ON_CYCLES),
    .BAT_ON_CYCLES(BAT_ON_CYCLES)
) mon_u (.i_clk, .i_sys_rst, .i_spi_cs_n, .i_low_power_req, .o_irq_n, .o_irq_pending_flag,
    .o_low_power_state, .o_ground_poll_en, .o_battery_poll_en);

// File: swmon_irq_lowpower_tb.sv
/*
 * Self-checking bench: register resets, unused bits, interrupt enables, wake timer, polling.
 * Assumes the host model on the serial side and shortened tick and on-time parameters.
 */
`timescale 1ns/1ps
module swmon_irq_lowpower_tb
    import swmon_pkg::*;
;
    localparam int TICK = 20;
    logic i_clk, i_sys_rst, sclk, cs_n, mosi, lp_req;
    logic [7:0] prog_in;
    logic [13:0] gnd_in;
    logic miso, miso_oe, irq_n, flag, lp_state, gnd_poll, bat_poll;
    int bad_count, cmp_count, cyc;
    int int_ms[16] = '{0, 6, 12, 24, 48, 96, 192, 394, 4, 8, 16, 32, 64, 128, 256, 512};
    int poll_ms[16] = '{3, 6, 12, 24, 48, 68, 76, 128, 32, 36, 40, 44, 52, 56, 60, 64};

    swmon_host_model host_u (.o_spi_sclk(sclk), .o_spi_cs_n(cs_n), .o_spi_mosi(mosi), .i_spi_miso(miso));
    swmon_irq_lowpower #(.TICK_CYCLES(TICK), .GND_ON_CYCLES(3), .BAT_ON_CYCLES(5)) dut_u (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_spi_sclk(sclk), .i_spi_cs_n(cs_n), .i_spi_mosi(mosi),
        .i_programmable_input(prog_in), .i_ground_switch_input(gnd_in), .i_low_power_req(lp_req),
        .o_spi_miso(miso), .o_spi_miso_oe(miso_oe), .o_irq_n(irq_n), .o_irq_pending_flag(flag),
        .o_low_power_state(lp_state), .o_ground_poll_en(gnd_poll), .o_battery_poll_en(bat_poll));

    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    // Ceiling well above the roughly 80k cycles the scenarios need
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 95000) begin
            bad_count++;
            test_done();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Tolerance covers synchroniser and entry latency
    task automatic near(input int got, input int exp);
        cmp_count++;
        if (got < exp - 3 || got > exp + 3) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : near

    task automatic wr(input logic [6:0] a, input logic [23:0] d);
        logic [31:0] r;
        host_u.frame({a, 1'b1, d}, r);
    endtask : wr

    // Response is one frame late, so a second frame fetches it
    task automatic rd(input logic [6:0] a, output logic [31:0] r);
        host_u.frame({a, 1'b0, 24'h000000}, r);
        host_u.frame({a, 1'b0, 24'h000000}, r);
        chk(r[31:23], {a, 2'b00});
    endtask : rd

    task automatic irq_case(input logic gnd, input int b, input logic exp);
        logic [31:0] r;
        @(negedge i_clk);
        if (gnd)
            gnd_in[b] = ~gnd_in[b];
        else
            prog_in[b] = ~prog_in[b];
        repeat (8) @(negedge i_clk);
        chk(flag, exp);
        chk(irq_n, !exp);
        rd(ADDR_LP_CFG, r);
        chk(r[22], exp);
        chk(flag, 1'b0);
    endtask : irq_case

    task automatic wait_poll(output int n);
        n = 0;
        while (gnd_poll === 1'b1) begin
            @(negedge i_clk);
            n++;
        end
        while (gnd_poll !== 1'b1 && n < 3000) begin
            @(negedge i_clk);
            n++;
        end
    endtask : wait_poll

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_vals;
        logic [31:0] r;
        rd(ADDR_PROG_IRQ_EN, r);
        chk(r[21:0], 22'h0000ff);
        rd(ADDR_GND_IRQ_EN, r);
        chk(r[21:0], 22'h003fff);
        rd(ADDR_LP_CFG, r);
        chk(r[21:0], 22'h00000f);
        chk(miso_oe, 1'b0);
    endtask : t_reset_vals

    task automatic t_unused;
        logic [31:0] r;
        wr(ADDR_PROG_IRQ_EN, 24'hffff5a);
        rd(ADDR_PROG_IRQ_EN, r);
        chk(r[21:0], 22'h00005a);
        wr(ADDR_GND_IRQ_EN, 24'hffffff);
        rd(ADDR_GND_IRQ_EN, r);
        chk(r[21:0], 22'h003fff);
        wr(ADDR_LP_CFG, 24'hffff3c);
        rd(ADDR_LP_CFG, r);
        chk(r[21:0], 22'h00003c);
        wr(7'h10, 24'hffffff);
        rd(7'h10, r);
        chk(r[21:0], 22'h000000);
    endtask : t_unused

    task automatic t_irq;
        wr(ADDR_GND_IRQ_EN, 24'h000020);
        irq_case(1'b1, 5, 1'b1);
        irq_case(1'b1, 4, 1'b0);
        wr(ADDR_GND_IRQ_EN, 24'h002000);
        irq_case(1'b1, 13, 1'b1);
        irq_case(1'b1, 5, 1'b0);
        wr(ADDR_PROG_IRQ_EN, 24'h000001);
        irq_case(1'b0, 0, 1'b1);
        irq_case(1'b0, 7, 1'b0);
    endtask : t_irq

    task automatic t_wake;
        int n;
        for (int c = 0; c < 16; c++) begin
            wr(ADDR_LP_CFG, {16'h0000, c[3:0], 4'hf});
            @(negedge i_clk);
            lp_req = 1'b1;
            n = 0;
            do begin
                @(negedge i_clk);
                n++;
            end while (lp_state === 1'b1 && n < 11000);
            if (c == 0) begin
                chk(lp_state, 1'b1);
            end else begin
                near(n, int_ms[c] * TICK);
                chk(flag, 1'b1);
            end
            @(negedge i_clk);
            lp_req = 1'b0;
            repeat (2) @(negedge i_clk);
        end
    endtask : t_wake

    task automatic t_poll;
        int n;
        for (int c = 0; c < 16; c++) begin
            wr(ADDR_LP_CFG, {16'h0000, 4'h0, c[3:0]});
            @(negedge i_clk);
            lp_req = 1'b1;
            wait_poll(n);
            near(n, poll_ms[c] * TICK);
            chk(bat_poll, 1'b1);
            wait_poll(n);
            near(n, poll_ms[c] * TICK);
            // Let both poll pulses run out, a cut pulse would break the on-time check
            repeat (6) @(negedge i_clk);
            lp_req = 1'b0;
            repeat (2) @(negedge i_clk);
        end
    endtask : t_poll

    initial begin
        i_sys_rst = 1'b1;
        lp_req = 1'b0;
        prog_in = 8'h00;
        gnd_in = 14'h0000;
        repeat (6) @(negedge i_clk);
        i_sys_rst = 1'b0;
        repeat (3) @(negedge i_clk);
        t_reset_vals();
        t_unused();
        t_irq();
        t_wake();
        t_poll();
        test_done();
    end
endmodule : swmon_irq_lowpower_tb

// File: swmon_pkg.sv
/*
 * Shared constants for the switch monitor interrupt and low-power configuration block:
 * serial frame layout, register addresses, reset values, timing constants and period tables.
 * Assumes a 20 MHz core clock and 32-bit serial frames (7-bit address, R/W bit, 24-bit data).
 */
package swmon_pkg;

    // ------------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------------
    localparam int FRAME_BITS    = 32;
    localparam int ADDR_MSB      = 31;
    localparam int ADDR_LSB      = 25;
    localparam int RW_BIT        = 24;
    localparam int FAULT_BIT     = 23;
    localparam int FLAG_BIT      = 22;
    localparam int DATA_W        = 24;
    localparam int RDATA_W       = 22;

    // ------------------------------------------------------------------
    // Register addresses (7-bit) and layout
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_PROG_IRQ_EN = 7'h0d;
    localparam logic [6:0] ADDR_GND_IRQ_EN  = 7'h0e;
    localparam logic [6:0] ADDR_LP_CFG      = 7'h0f;
    localparam int NUM_PROG      = 8;
    localparam int NUM_GND       = 14;
    localparam int INT_SEL_MSB   = 7;
    localparam int INT_SEL_LSB   = 4;
    localparam int POLL_SEL_MSB  = 3;
    localparam int POLL_SEL_LSB  = 0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  PROG_IRQ_EN_RST = 8'hff;
    localparam logic [13:0] GND_IRQ_EN_RST  = 14'h3fff;
    localparam logic [7:0]  LP_CFG_RST      = 8'h0f;
    localparam logic [3:0]  INT_SEL_OFF     = 4'h0;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ             = 20_000_000;
    localparam int MS_TICK_CYCLES     = CLK_HZ / 1000;
    localparam int GND_POLL_ON_US     = 50;
    localparam int BAT_POLL_ON_US     = 100;
    localparam int GND_POLL_ON_CYCLES = (GND_POLL_ON_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int BAT_POLL_ON_CYCLES = (BAT_POLL_ON_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int MS_W               = 10;

    typedef enum logic [0:0] {
        MODE_NORMAL,
        MODE_LOW_POWER
    } mode_t;

    // Interrupt timer period in ms; zero means the timer is off
    function automatic logic [MS_W-1:0] int_period_ms(input logic [3:0] sel);
        logic [MS_W-1:0] ms;
        ms = 10'h000;
        unique case (sel)
            4'h0: ms = 10'h000;
            4'h1: ms = 10'h006;
            4'h2: ms = 10'h00c;
            4'h3: ms = 10'h018;
            4'h4: ms = 10'h030;
            4'h5: ms = 10'h060;
            4'h6: ms = 10'h0c0;
            4'h7: ms = 10'h18a;
            4'h8: ms = 10'h004;
            4'h9: ms = 10'h008;
            4'ha: ms = 10'h010;
            4'hb: ms = 10'h020;
            4'hc: ms = 10'h040;
            4'hd: ms = 10'h080;
            4'he: ms = 10'h100;
            4'hf: ms = 10'h200;
        endcase
        return ms;
    endfunction : int_period_ms

    // Polling interval in ms, from one polling event to the next
    function automatic logic [MS_W-1:0] poll_period_ms(input logic [3:0] sel);
        logic [MS_W-1:0] ms;
        ms = 10'h000;
        unique case (sel)
            4'h0: ms = 10'h003;
            4'h1: ms = 10'h006;
            4'h2: ms = 10'h00c;
            4'h3: ms = 10'h018;
            4'h4: ms = 10'h030;
            4'h5: ms = 10'h044;
            4'h6: ms = 10'h04c;
            4'h7: ms = 10'h080;
            4'h8: ms = 10'h020;
            4'h9: ms = 10'h024;
            4'ha: ms = 10'h028;
            4'hb: ms = 10'h02c;
            4'hc: ms = 10'h034;
            4'hd: ms = 10'h038;
            4'he: ms = 10'h03c;
            4'hf: ms = 10'h040;
        endcase
        return ms;
    endfunction : poll_period_ms

endpackage : swmon_pkg

// File: swmon_serial_link.sv
/*
 * Serial link front end, clocked by the host's serial clock.
 * Shifts in one 32-bit frame MSB first on rising edges and shifts the response word out.
 * Assumes the select is held high between frames, the serial clock stands still outside
 * frames, and the response word input is stable whenever a frame is in progress.
 */
`timescale 1ns/1ps
module swmon_serial_link
    import swmon_pkg::*;
(
    input  wire logic                  i_spi_sclk,
    input  wire logic                  i_spi_cs_n,
    input  wire logic                  i_spi_mosi,
    input  wire logic [FRAME_BITS-1:0] i_tx_word,
    output logic      [FRAME_BITS-1:0] o_rx_word,
    output logic                       o_rx_done,
    output logic                       o_miso
);

    typedef struct packed {
        logic [5:0]            cnt;
        logic [FRAME_BITS-1:0] rx;
        logic [FRAME_BITS-1:0] tx;
        logic                  miso;
        logic                  done;
    } link_t;

    localparam link_t LINK_IDLE = '{cnt: 6'h00, rx: 32'h0000_0000, tx: 32'h0000_0000, miso: 1'b0, done: 1'b0};
    localparam logic [5:0] LAST_BIT = 6'(FRAME_BITS - 1);
    localparam logic [5:0] FULL     = 6'(FRAME_BITS);

    link_t q;
    link_t next_q;
    logic [FRAME_BITS-1:0] tx_src;

    always_comb begin
        next_q = q;
        tx_src = (q.cnt == 6'h00) ? i_tx_word : q.tx;
        // Extra clocks past a full frame are ignored so the word stays stable for capture
        if (q.cnt != FULL) begin
            next_q.rx   = {q.rx[FRAME_BITS-2:0], i_spi_mosi};
            next_q.miso = tx_src[FRAME_BITS-1];
            next_q.tx   = {tx_src[FRAME_BITS-2:0], 1'b0};
            next_q.cnt  = q.cnt + 6'h01;
            if (q.cnt == LAST_BIT) begin
                next_q.done = 1'b1;
            end
        end
    end

    // The select is the only reset this domain sees; the clock is absent between frames
    always_ff @(posedge i_spi_sclk or posedge i_spi_cs_n) begin
        if (i_spi_cs_n) begin
            q <= LINK_IDLE;
        end else begin
            q <= next_q;
        end
    end

    assign o_rx_word = q.rx;
    assign o_rx_done = q.done;
    assign o_miso    = q.miso;

endmodule : swmon_serial_link
